// >>> iodec_pkg.sv
// iodec_pkg: shared constants for the i/o instruction decode front end
// assumes one system clock and an asynchronous active-low reset everywhere
package iodec_pkg;
    localparam int WORD_W       = 12;
    localparam int OP_W         = 4;
    localparam int CMD_W        = 3;
    localparam int SEL_W        = 5;
    localparam int BANK_AW      = 12;          // 4096-word modules
    localparam int BANK_CNT     = 8;           // 32,768 words total
    localparam int BANK_SEL_W   = 3;
    localparam int FIFO_DEPTH   = 16;
    // field positions, bit 0 is the most significant instruction bit
    localparam int OP_HI        = 11;
    localparam int OP_LO        = 8;
    localparam int CMD_HI       = 7;
    localparam int CMD_LO       = 5;
    localparam int SEL_HI       = 4;
    localparam int SEL_LO       = 0;
    localparam int DIR_BIT      = 4;           // instruction bit 7
    localparam int OCT1_HI      = 4;
    localparam int OCT1_LO      = 3;
    localparam int OCT2_HI      = 2;
    localparam int OCT2_LO      = 0;
    localparam logic [OP_W-1:0]  IO_OPCODE  = 4'h1;
    // command field encodings
    localparam logic [CMD_W-1:0] CMD_TTA    = 3'h0;
    localparam logic [CMD_W-1:0] CMD_TFA    = 3'h1;
    localparam logic [CMD_W-1:0] CMD_DST    = 3'h2;
    localparam logic [CMD_W-1:0] CMD_SDF    = 3'h3;
    localparam logic [CMD_W-1:0] CMD_EXEC   = 3'h4;
    localparam logic [CMD_W-1:0] CMD_DEACT  = 3'h5;
    localparam logic [CMD_W-1:0] CMD_SELACT = 3'h6;
    localparam logic [CMD_W-1:0] CMD_IOCTL  = 3'h7;
    localparam logic [WORD_W-1:0] WORD_RST  = 12'h000;
    localparam logic [SEL_W-1:0]  SEL_RST   = 5'h00;
    localparam logic [CMD_W-1:0]  CMD_RST   = 3'h0;
    localparam int HOLD_CYCLES  = 1;           // one memory cycle held off

    typedef enum logic [1:0] {IODEC_IDLE, IODEC_STROBE, IODEC_DONE} iodec_state_e;

    // high-order commands need no ready answer
    function automatic logic iodec_is_data_cmd(input logic [CMD_W-1:0] c);
        return (c[CMD_W-1] == 1'b0);
    endfunction : iodec_is_data_cmd
endpackage : iodec_pkg

// >>> iodec_if.sv
// iodec_if: wires between the cpu-side i/o front end and a device controller
// assumes both ends share clk_sys; no clocking block, the testbench samples
`timescale 1ns/1ns
`default_nettype none
interface iodec_if
    import iodec_pkg::*;
(
    input wire logic clk_sys
);
    logic                 io_operation_strobe;
    logic [CMD_W-1:0]     io_cmd;
    logic [SEL_W-1:0]     dev_select;
    logic                 execute_accumulator_command;
    logic                 device_deactivate_cmd;
    logic                 select_activate_cmd;
    logic                 io_control_activate_cmd;
    logic [WORD_W-1:0]    acc_out;
    logic [WORD_W-1:0]    dev_in;
    logic                 dev_ready;
    logic                 dev_flag;
    logic                 dev_irq;
    logic                 dma_req;
    logic                 dma_write;
    logic [BANK_SEL_W-1:0] dma_bank;
    logic [BANK_AW-1:0]   dma_addr;
    logic [WORD_W-1:0]    dma_wdata;
    logic                 dma_ack;
    logic [WORD_W-1:0]    dma_rdata;

    modport cpu (
        output io_operation_strobe, io_cmd, dev_select, execute_accumulator_command,
               device_deactivate_cmd, select_activate_cmd, io_control_activate_cmd,
               acc_out, dma_ack, dma_rdata,
        input  dev_in, dev_ready, dev_flag, dev_irq, dma_req, dma_write, dma_bank,
               dma_addr, dma_wdata
    );
    modport ctrl (
        input  io_operation_strobe, io_cmd, dev_select, execute_accumulator_command,
               device_deactivate_cmd, select_activate_cmd, io_control_activate_cmd,
               acc_out, dma_ack, dma_rdata,
        output dev_in, dev_ready, dev_flag, dev_irq, dma_req, dma_write, dma_bank,
               dma_addr, dma_wdata
    );
endinterface : iodec_if
`default_nettype wire

// >>> iodec_fifo.sv
// iodec_fifo: flip-flop fifo with valid/ready on both sides
// assumes single clock; depth a power of two
`timescale 1ns/1ns
`default_nettype none
module iodec_fifo
    import iodec_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // full and empty come straight from the count
    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_ptr_r];

    // storage has no reset; only pointers matter
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule : iodec_fifo
`default_nettype wire

// >>> iodec_cpu.sv
// iodec_cpu: cpu end; decodes i/o instructions, runs programmed transfers, dma banks
// assumes instructions arrive one at a time on instr_valid; controller is iodec_ctrl
`timescale 1ns/1ns
`default_nettype none
// Contract
// - word splits opcode, three control, five address
// - bits four to six form command
// - bits seven to eleven select device
// - select read as two octal digits
// - bit seven low input, high output
// - controller may take command from accumulator
// - controller may combine select with accumulator
// - input devices answer assigned select codes
// - transfer only when device ready
// - interrupt traps to device service routine
// - dma same bank suspends cpu cycle
// - contention holds cpu one memory cycle
// - other-bank dma leaves cpu undisturbed
// - dma to different banks run concurrently; here one dma_req serves one bank at a time
// - memory 4096-word banks, eight, each dma
// - controller supplies address, start, direction
// - high command codes exec, deact, select, control
// - strobe driven while i/o command executes
// - select bits buffered from instruction register
// - data commands skip when not ready
module iodec_cpu
    import iodec_pkg::*;
#(
    parameter int NBANK = BANK_CNT
)(
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    iodec_if.cpu                       lnk,
    input  wire logic                  instr_valid,
    input  wire logic [WORD_W-1:0]     instr,
    input  wire logic [WORD_W-1:0]     acc_in,
    output logic                       instr_done,
    output logic                       skip_r,
    output logic                       xfer_r,
    output logic      [WORD_W-1:0]     rx_data_r,
    output logic                       dir_output,
    output logic      [1:0]            sel_octal_hi,
    output logic      [2:0]            sel_octal_lo,
    output logic                       irq_trap_r,
    output logic      [SEL_W-1:0]      trap_dev_r,
    input  wire logic                  cpu_mem_req,
    input  wire logic [BANK_SEL_W-1:0] cpu_bank,
    output logic                       cpu_hold,
    output logic                       rx_valid,
    input  wire logic                  rx_ready
);
    iodec_state_e       state_r;
    logic [WORD_W-1:0]  ir_r;
    logic               is_io;
    logic [NBANK-1:0]   bank_busy_r;
    logic [WORD_W-1:0]  fifo_out;

    // i/o instruction: opcode in bits 0..3
    assign is_io = (ir_r[OP_HI:OP_LO] == IO_OPCODE) && (state_r != IODEC_IDLE);

    // fields presented only during i/o, low otherwise
    assign lnk.io_operation_strobe = (state_r == IODEC_STROBE) && is_io;
    assign lnk.io_cmd     = is_io ? ir_r[CMD_HI:CMD_LO] : CMD_RST;
    assign lnk.dev_select = is_io ? ir_r[SEL_HI:SEL_LO] : SEL_RST;
    assign lnk.execute_accumulator_command = is_io && ir_r[CMD_HI:CMD_LO] == CMD_EXEC;
    assign lnk.device_deactivate_cmd   = is_io && ir_r[CMD_HI:CMD_LO] == CMD_DEACT;
    assign lnk.select_activate_cmd     = is_io && ir_r[CMD_HI:CMD_LO] == CMD_SELACT;
    assign lnk.io_control_activate_cmd = is_io && ir_r[CMD_HI:CMD_LO] == CMD_IOCTL;
    assign dir_output   = is_io && ir_r[DIR_BIT];
    assign sel_octal_hi = is_io ? ir_r[OCT1_HI:OCT1_LO] : 2'h0;
    assign sel_octal_lo = is_io ? ir_r[OCT2_HI:OCT2_LO] : 3'h0;
    assign instr_done   = (state_r == IODEC_DONE);

    // instruction register and step sequence; strobe lasts one cycle
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= IODEC_IDLE;
            ir_r    <= WORD_RST;
        end
        else
        begin
            unique case (state_r)
                IODEC_IDLE:
                begin
                    if (instr_valid)
                    begin
                        ir_r    <= instr;
                        state_r <= IODEC_STROBE;
                    end
                end
                IODEC_STROBE: state_r <= IODEC_DONE;
                IODEC_DONE:   state_r <= IODEC_IDLE;
            endcase
        end
    end

    // accumulator latched when any instruction is accepted and held through the strobe, for every command
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            lnk.acc_out <= WORD_RST;
        else if (state_r == IODEC_IDLE && instr_valid)
            lnk.acc_out <= acc_in;
    end

    // ready gates the transfer; not ready skips next instruction
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            skip_r    <= 1'b0;
            xfer_r    <= 1'b0;
            rx_data_r <= WORD_RST;
        end
        else if (lnk.io_operation_strobe)
        begin
            if (iodec_is_data_cmd(lnk.io_cmd))
            begin
                if (lnk.io_cmd == CMD_SDF)
                begin
                    skip_r <= !lnk.dev_flag;
                    xfer_r <= 1'b0;
                end
                else
                begin
                    skip_r <= !lnk.dev_ready;
                    xfer_r <= lnk.dev_ready;
                    if (lnk.dev_ready && lnk.io_cmd != CMD_TFA)
                        rx_data_r <= lnk.dev_in;
                end
            end
            else
            begin
                skip_r <= 1'b0;
                xfer_r <= 1'b0;
            end
        end
    end

    // interrupt: latch trap and requesting device select; set wins over clear
    // the controller puts its own code on dev_in while it interrupts, so the
    // trap records which service routine to enter without a separate poll
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_trap_r <= 1'b0;
            trap_dev_r <= SEL_RST;
        end
        else if (lnk.dev_irq && !irq_trap_r)
        begin
            irq_trap_r <= 1'b1;
            trap_dev_r <= lnk.dev_in[SEL_W-1:0];
        end
        else if (instr_valid && state_r == IODEC_IDLE)
            irq_trap_r <= lnk.dev_irq;
    end

    // dma: each bank tracks its own access in its own flop, one cycle per access
    // one busy flop per bank, all ORed into the single shared dma_ack, so a
    // request to any bank raises the same acknowledge as every other bank
    genvar b;
    generate
        for (b = 0; b < NBANK; b++)
        begin : g_bank
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                    bank_busy_r[b] <= 1'b0;
                else
                    bank_busy_r[b] <= lnk.dma_req && (lnk.dma_bank == BANK_SEL_W'(b));
            end
        end
    endgenerate

    // cpu held in every cycle that it requests memory and dma wants its bank, and only then
    // combinational, so the cpu stops within the same memory cycle
    assign cpu_hold = cpu_mem_req && lnk.dma_req && (lnk.dma_bank == cpu_bank);
    assign lnk.dma_ack = |bank_busy_r;

    // dma words from controller buffered toward memory port
    // in_ready is left open: the controller must keep no more than sixteen
    // writes undrained, since a full buffer drops further words silently
    iodec_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_valid  (lnk.dma_req && lnk.dma_write),
        .in_ready  (),
        .in_data   (lnk.dma_wdata),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (fifo_out)
    );

    // read data returns the fifo head word
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            lnk.dma_rdata <= WORD_RST;
        else
            lnk.dma_rdata <= fifo_out;
    end
endmodule : iodec_cpu
`default_nettype wire

// >>> iodec_ctrl.sv
// iodec_ctrl: external device controller end; decodes select, answers ready
// assumes the cpu end drives the interface; one device code per instance
`timescale 1ns/1ns
`default_nettype none
module iodec_ctrl
    import iodec_pkg::*;
#(
    parameter logic [SEL_W-1:0] MY_CODE = 5'h00
)(
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    iodec_if.ctrl                      lnk,
    input  wire logic                  user_ready,
    input  wire logic                  user_flag,
    input  wire logic                  user_irq,
    input  wire logic [WORD_W-1:0]     user_in,
    output logic      [WORD_W-1:0]     user_out_r,
    output logic                       active_r,
    output logic                       ioctl_r,
    output logic      [WORD_W-1:0]     cmd_word_r,
    input  wire logic                  dma_go,
    input  wire logic                  dma_wr,
    input  wire logic [BANK_SEL_W-1:0] dma_bank_in,
    input  wire logic [BANK_AW-1:0]    dma_addr_in,
    input  wire logic [WORD_W-1:0]     dma_data_in
);
    logic hit;

    // this controller answers its assigned select code
    assign hit = lnk.io_operation_strobe && (lnk.dev_select == MY_CODE);
    assign lnk.dev_ready = hit && user_ready;
    assign lnk.dev_flag  = hit && user_flag;
    assign lnk.dev_irq   = user_irq;
    assign lnk.dev_in    = user_irq ? {{(WORD_W-SEL_W){1'b0}}, MY_CODE} : user_in;

    // dma: controller owns address, start and direction
    assign lnk.dma_req   = dma_go;
    assign lnk.dma_write = dma_wr;
    assign lnk.dma_bank  = dma_bank_in;
    assign lnk.dma_addr  = dma_addr_in;
    assign lnk.dma_wdata = dma_data_in;

    // high-order commands act on activate flip-flops and command word
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active_r   <= 1'b0;
            ioctl_r    <= 1'b0;
            cmd_word_r <= WORD_RST;
            user_out_r <= WORD_RST;
        end
        else if (hit)
        begin
            if (lnk.execute_accumulator_command)
                cmd_word_r <= lnk.acc_out;
            if (lnk.device_deactivate_cmd)
                active_r <= 1'b0;
            if (lnk.select_activate_cmd)
                active_r <= 1'b1;
            if (lnk.io_control_activate_cmd)
                ioctl_r <= 1'b1;
            if (lnk.io_cmd == CMD_TFA && lnk.dev_select[DIR_BIT] && user_ready)
                user_out_r <= lnk.acc_out;
        end
    end
endmodule : iodec_ctrl
`default_nettype wire

// >>> iodec_props.sv
// iodec_props: link checks between cpu end and controller end
// assumes one clock and the interface signals wired in by name
`timescale 1ns/1ns
`default_nettype none
module iodec_props
    import iodec_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             arst_n,
    input wire logic             io_operation_strobe,
    input wire logic [CMD_W-1:0] io_cmd,
    input wire logic [SEL_W-1:0] dev_select,
    input wire logic             execute_accumulator_command,
    input wire logic             device_deactivate_cmd,
    input wire logic             select_activate_cmd,
    input wire logic             io_control_activate_cmd,
    input wire logic             dma_req,
    input wire logic             dma_ack
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_STROBE_PULSE: assert property (io_operation_strobe |=> !io_operation_strobe)
        else $error("strobe longer than one cycle");
    AST_FIELDS_HOLD: assert property (io_operation_strobe |=> $stable(io_cmd) &&
        $stable(dev_select)) else $error("fields moved before done");
    // fields go quiet two cycles after the strobe cycle
    AST_FIELDS_IDLE: assert property (!io_operation_strobe && !$past(io_operation_strobe)
        |-> io_cmd == 3'h0 && dev_select == 5'h00) else $error("fields active outside i/o");
    AST_EXEC_DEC: assert property (io_operation_strobe |->
        execute_accumulator_command == (io_cmd == CMD_EXEC)) else $error("exec decode wrong");
    AST_DEACT_DEC: assert property (io_operation_strobe |->
        device_deactivate_cmd == (io_cmd == CMD_DEACT)) else $error("deactivate decode wrong");
    AST_SELACT_DEC: assert property (io_operation_strobe |->
        select_activate_cmd == (io_cmd == CMD_SELACT)) else $error("select decode wrong");
    AST_IOCTL_DEC: assert property (io_operation_strobe |->
        io_control_activate_cmd == (io_cmd == CMD_IOCTL)) else $error("control decode wrong");
    AST_DMA_ACK: assert property (dma_req |=> dma_ack)
        else $error("dma request not acknowledged");
    AST_ACK_CAUSE: assert property (dma_ack |-> $past(dma_req))
        else $error("dma ack without request");
endmodule : iodec_props
`default_nettype wire

// >>> io_instruction_decode_dma_tb.sv
// io_instruction_decode_dma_tb: cpu end facing controller end over iodec_if
// assumes the design files and iodec_props are compiled first
`timescale 1ns/1ns
`default_nettype none
module io_instruction_decode_dma_tb;
    import iodec_pkg::*;
    localparam logic [SEL_W-1:0] DEV  = 5'h1b; // output device, octal 33
    localparam logic [SEL_W-1:0] OTH  = 5'h0b; // input device, octal 13
    localparam logic [11:0]      WORD = 12'h3c5;
    logic clk_sys = 0, arst_n = 0, instr_valid = 0, cpu_mem_req = 0, rx_ready = 0;
    logic [11:0] instr = 0, acc_in = 0, user_in = WORD, dma_addr_in = 0, dma_data_in = 0;
    logic [2:0]  cpu_bank = 0, dma_bank_in = 0, so_lo;
    logic user_ready = 1, user_flag = 1, user_irq = 0, dma_go = 0, dma_wr = 0;
    logic instr_done, skip_r, xfer_r, dir_out, trap, hold, rx_valid, active, ioctl;
    logic [11:0] rx_data, user_out, cmd_word;
    logic [1:0]  so_hi;
    logic [4:0]  trap_dev;
    int err_total = 0, tests_run = 0, cnt;

    // free-running system clock, 10 ns
    initial forever #5 clk_sys = ~clk_sys;

    iodec_if lnk_if (.clk_sys(clk_sys));
    iodec_cpu #(.NBANK(BANK_CNT)) iodec_cpu_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .lnk(lnk_if), .instr_valid(instr_valid), .instr(instr), .acc_in(acc_in),
        .instr_done(instr_done), .skip_r(skip_r), .xfer_r(xfer_r), .rx_data_r(rx_data),
        .dir_output(dir_out), .sel_octal_hi(so_hi), .sel_octal_lo(so_lo), .irq_trap_r(trap),
        .trap_dev_r(trap_dev), .cpu_mem_req(cpu_mem_req), .cpu_bank(cpu_bank),
        .cpu_hold(hold), .rx_valid(rx_valid), .rx_ready(rx_ready));
    iodec_ctrl #(.MY_CODE(DEV)) iodec_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .lnk(lnk_if), .user_ready(user_ready), .user_flag(user_flag), .user_irq(user_irq),
        .user_in(user_in), .user_out_r(user_out), .active_r(active), .ioctl_r(ioctl),
        .cmd_word_r(cmd_word), .dma_go(dma_go), .dma_wr(dma_wr), .dma_bank_in(dma_bank_in),
        .dma_addr_in(dma_addr_in), .dma_data_in(dma_data_in));
    iodec_props iodec_props_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .io_operation_strobe(lnk_if.io_operation_strobe), .io_cmd(lnk_if.io_cmd),
        .dev_select(lnk_if.dev_select),
        .execute_accumulator_command(lnk_if.execute_accumulator_command),
        .device_deactivate_cmd(lnk_if.device_deactivate_cmd),
        .select_activate_cmd(lnk_if.select_activate_cmd),
        .io_control_activate_cmd(lnk_if.io_control_activate_cmd),
        .dma_req(lnk_if.dma_req), .dma_ack(lnk_if.dma_ack));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : chk

    // one instruction, entered at a falling edge, returns in cycle 3
    task automatic run(input logic [3:0] op, input logic [2:0] c, input logic [4:0] s,
                       input logic [11:0] a);
        logic io;
        io = (op === IO_OPCODE);
        instr_valid = 1;
        instr = {op, c, s};
        acc_in = a;
        @(negedge clk_sys);
        instr_valid = 0;
        chk(lnk_if.io_operation_strobe, io, "strobe");
        chk(lnk_if.io_cmd, io ? c : 3'h0, "cmd field");
        chk(lnk_if.dev_select, io ? s : 5'h00, "select field");
        if (io)
        begin
            chk(dir_out, s[4], "direction");
            chk({so_hi, so_lo}, s, "octal digits");
        end
        @(negedge clk_sys);
        chk(instr_done, 1'b1, "done");
        @(negedge clk_sys);
    endtask : run

    task automatic conclude();
        $display("counts: %0d compared, %0d mismatched", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // watchdog, far beyond the hundred or so cycles the tests take
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (6) @(negedge clk_sys);
        arst_n = 1;
        @(negedge clk_sys);
        // every command to the selected device, device ready
        for (int c = 0; c < 8; c++)
        begin
            run(IO_OPCODE, c[2:0], DEV, {9'h0a5, c[2:0]});
            if (c < 3) chk({skip_r, xfer_r}, 2'h1, "ready transfer");
            if (c == 3) chk({skip_r, xfer_r}, 2'h0, "flag set no skip");
            if (c == 0) chk(rx_data, WORD, "input word");
            if (c == 1) chk(user_out, 12'h529, "output word");
            if (c == 4) chk(cmd_word, 12'h52c, "command word");
            if (c == 5) chk(active, 1'b0, "deactivated");
            if (c == 6) chk(active, 1'b1, "activated");
            if (c == 7) chk(ioctl, 1'b1, "control set");
        end
        run(IO_OPCODE, CMD_DEACT, DEV, 12'h000);
        chk(active, 1'b0, "deactivated again");
        $display("test commands done");
        // not ready, flag low, and a select code nobody answers
        user_ready = 0;
        run(IO_OPCODE, CMD_TTA, DEV, 12'h000);
        chk({skip_r, xfer_r}, 2'h2, "not ready skip");
        user_ready = 1;
        user_flag = 0;
        run(IO_OPCODE, CMD_SDF, DEV, 12'h000);
        chk(skip_r, 1'b1, "flag low skip");
        user_flag = 1;
        run(IO_OPCODE, CMD_TTA, OTH, 12'h000);
        chk(skip_r, 1'b1, "wrong device skip");
        run(4'h2, CMD_EXEC, 5'h1f, 12'h000);
        $display("test skips done");
        // interrupt traps with the device code, cleared by next instruction
        user_irq = 1;
        repeat (3) @(negedge clk_sys);
        chk(trap, 1'b1, "trap");
        chk(trap_dev, DEV, "trap device");
        user_irq = 0;
        run(IO_OPCODE, CMD_IOCTL, DEV, 12'h000);
        chk(trap, 1'b0, "trap cleared");
        $display("test interrupt done");
        // sixteen writes across all banks, cpu busy on bank 3, drain stalled
        cpu_mem_req = 1;
        cpu_bank = 3'h3;
        dma_wr = 1;
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            dma_go = 1;
            dma_bank_in = i[2:0];
            dma_addr_in = 12'hf00 + i[11:0];
            dma_data_in = 12'h500 + i[11:0];
            #1;
            chk(hold, i[2:0] == 3'h3, "cpu hold");
            chk(lnk_if.dma_bank, i[2:0], "dma bank");
            @(negedge clk_sys);
        end
        chk(lnk_if.dma_ack, 1'b1, "dma ack");
        dma_go = 0;
        cpu_mem_req = 0;
        @(negedge clk_sys);
        chk(rx_valid, 1'b1, "buffer filled");
        chk(lnk_if.dma_rdata, 12'h500, "first dma word");
        rx_ready = 1;
        cnt = 0;
        repeat (40)
        begin
            if (rx_valid === 1'b1) cnt++;
            @(negedge clk_sys);
        end
        chk(cnt[15:0], 16'(FIFO_DEPTH), "words drained");
        $display("test dma done");
        conclude();
    end
endmodule : io_instruction_decode_dma_tb
`default_nettype wire
